// *** rtl/pfh_map.svh ***
`ifndef PFH_MAP_SVH
`define PFH_MAP_SVH

// ************************************************************
// Clock rate and conversion of times to whole cycles
// ************************************************************
`define PFH_CLK_MHZ        40
// Least times round up to whole cycles
`define PFH_CYC_UP(ns)     ((((ns) * `PFH_CLK_MHZ) + 999) / 1000)

// ************************************************************
// Flash timing figures in nanoseconds
// ************************************************************
`define PFH_T_RP_NS        500
`define PFH_T_READY_NS     20000
`define PFH_T_RH_NS        50
`define PFH_T_RPD_NS       20000
`define PFH_T_FLQZ_NS      30
`define PFH_T_FHQV_NS      120
`define PFH_T_WC_NS        70
`define PFH_T_WP_NS        35
`define PFH_T_WPH_NS       30
`define PFH_T_BUSY_NS      90
`define PFH_T_RSP_NS       4000
`define PFH_T_VIDR_NS      500
`define PFH_T_ACC_NS       70

// ************************************************************
// Derived cycle counts
// ************************************************************
`define PFH_C_RP           `PFH_CYC_UP(`PFH_T_RP_NS)
`define PFH_C_RPD          `PFH_CYC_UP(`PFH_T_RPD_NS)
`define PFH_C_RH           `PFH_CYC_UP(`PFH_T_RH_NS)
`define PFH_C_READY_REC    (`PFH_CYC_UP(`PFH_T_READY_NS) - `PFH_C_RP)
`define PFH_C_FLQZ         `PFH_CYC_UP(`PFH_T_FLQZ_NS)
`define PFH_C_FHQV         `PFH_CYC_UP(`PFH_T_FHQV_NS)
`define PFH_C_WC           `PFH_CYC_UP(`PFH_T_WC_NS)
`define PFH_C_WP           `PFH_CYC_UP(`PFH_T_WP_NS)
`define PFH_C_WPH          `PFH_CYC_UP(`PFH_T_WPH_NS)
`define PFH_C_BUSY         `PFH_CYC_UP(`PFH_T_BUSY_NS)
`define PFH_C_RSP          `PFH_CYC_UP(`PFH_T_RSP_NS)
`define PFH_C_VIDR         `PFH_CYC_UP(`PFH_T_VIDR_NS)
`define PFH_C_ACC          `PFH_CYC_UP(`PFH_T_ACC_NS)
// Extra cycles for the data synchroniser and one gap between reads
`define PFH_C_SYNC         3
`define PFH_C_GAP          1

// ************************************************************
// Register word offsets
// ************************************************************
`define PFH_REG_CTRL       3'h0
`define PFH_REG_ADDR       3'h1
`define PFH_REG_WDATA      3'h2
`define PFH_REG_RDATA      3'h3
`define PFH_REG_STATUS     3'h4
`define PFH_REG_TIM0       3'h5
`define PFH_REG_TIM1       3'h6

// ************************************************************
// Field positions
// ************************************************************
`define PFH_CTRL_BYTE      4
`define PFH_CTRL_STBY      5
`define PFH_CTRL_FORCE     6
`define PFH_ST_BUSY        0
`define PFH_ST_ERR         1
`define PFH_ST_READY       2
`define PFH_ST_TOG         3
`define PFH_ST_ESTOG       4
`define PFH_ST_HV          5
`define PFH_ST_BYTE        6
`define PFH_DQ_TOG         6
`define PFH_DQ_ESTOG       2
`define PFH_ADDR_B6        6
`define PFH_ADDR_B1        1
`define PFH_ADDR_B0        0

`endif

// *** rtl/pfh_pkg.sv ***
package pfh_pkg;

  // Controller states, one-hot
  typedef enum logic [10:0] {
    PFH_IDLE      = 11'b000_0000_0001,
    PFH_RD        = 11'b000_0000_0010,
    PFH_GAP       = 11'b000_0000_0100,
    PFH_WR_LO     = 11'b000_0000_1000,
    PFH_WR_HI     = 11'b000_0001_0000,
    PFH_RST_LO    = 11'b000_0010_0000,
    PFH_RST_HI    = 11'b000_0100_0000,
    PFH_BUSY_WAIT = 11'b000_1000_0000,
    PFH_RDY_WAIT  = 11'b001_0000_0000,
    PFH_HV_WAIT   = 11'b010_0000_0000,
    PFH_BYTE_WAIT = 11'b100_0000_0000
  } pfh_state_t;

  // Command codes in the control register
  typedef enum logic [3:0] {
    PFH_CMD_NOP    = 4'h0,
    PFH_CMD_READ   = 4'h1,
    PFH_CMD_WRITE  = 4'h2,
    PFH_CMD_RESET  = 4'h3,
    PFH_CMD_WAIT   = 4'h4,
    PFH_CMD_POLL   = 4'h5,
    PFH_CMD_HV_ON  = 4'h6,
    PFH_CMD_HV_OFF = 4'h7,
    PFH_CMD_PROT   = 4'h8,
    PFH_CMD_UNPROT = 4'h9,
    PFH_CMD_WIDTH  = 4'hA
  } pfh_cmd_t;

endpackage : pfh_pkg

// *** rtl/pfh_tmr_if.sv ***
interface pfh_tmr_if;
  logic        load;
  logic [11:0] value;
  logic        expired;

  // Controller side loads, timer side reports
  modport ctl (output load, output value, input expired);
  modport tmr (input load, input value, output expired);
endinterface : pfh_tmr_if

// *** rtl/pfh_timer.sv ***
module pfh_timer (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  // Load and expiry
  pfh_tmr_if.tmr    tif
);
  import pfh_pkg::*;

  logic [11:0] cnt_ff;

  // Down counter, reloaded on demand and parked at zero
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      cnt_ff <= 12'h000;
    else if (tif.load)
      cnt_ff <= tif.value;
    else if (cnt_ff != 12'h000)
      cnt_ff <= cnt_ff - 12'h001;
  end

  // A pending load hides a stale zero
  assign tif.expired = (cnt_ff == 12'h000) && !tif.load;

endmodule // pfh_timer

// *** rtl/pfh_host.sv ***
// The placing of the registers and the Avalon-MM interface to the registers were decided locally.
`include "pfh_map.svh"

module pfh_host (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  // Avalon-MM slave
  input  wire logic [2:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  // Flash address, data and strobes
  output logic      [20:0]       fl_addr,
  input  wire logic [15:0]       fl_dq_i,
  output logic      [15:0]       fl_dq_o,
  output logic                   fl_dq_oe,
  output logic                   fl_ce_n,
  output logic                   fl_oe_n,
  output logic                   fl_we_n,
  output logic                   fl_byte_n,
  output logic                   fl_reset_n,
  output logic                   fl_hv_en,
  input  wire logic              fl_done_flag_n,
  // Controller state for observation
  output pfh_pkg::pfh_state_t    fsm_state
);
  import pfh_pkg::*;

  // ************************************************************
  // Declarations
  // ************************************************************
  pfh_tmr_if   tif ();
  pfh_state_t  state_ff;
  logic        ack_ff;
  logic        acc_wr;
  logic [20:0] addr_ff;
  logic [15:0] wdata_ff;
  logic [15:0] rdata_ff;
  logic [23:0] tim0_ff;
  logic [23:0] tim1_ff;
  logic        err_ff;
  logic        tog_ff;
  logic        estog_ff;
  logic        poll_ff;
  logic        second_ff;
  logic        busy_at_ff;
  logic        stby_ff;
  logic        diff_tog_ff;
  logic        diff_es_ff;
  logic        diff_vld_ff;
  logic        load_ff;
  logic [11:0] value_ff;
  logic [15:0] dq_s1_ff;
  logic [15:0] dq_s2_ff;
  logic [15:0] dq_s3_ff;
  logic        rdy_s1_ff;
  logic        rdy_s2_ff;
  logic        rdy_s3_ff;
  logic        rdy_ff;
  logic        go;
  logic        go_ok;
  logic        go_bad;
  pfh_cmd_t    cmd;
  logic [3:0]  t_wp;
  logic [3:0]  t_wph;
  logic [3:0]  t_acc;

  // ************************************************************
  // Timer
  // ************************************************************
  assign tif.load  = load_ff;
  assign tif.value = value_ff;

  pfh_timer u_timer (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .tif     (tif.tmr)
  );

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  // Three stages; a change counts once stages two and three agree
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      rdy_s1_ff <= 1'b0;
      rdy_s2_ff <= 1'b0;
      rdy_s3_ff <= 1'b0;
      rdy_ff    <= 1'b0;
      dq_s1_ff  <= 16'h0000;
      dq_s2_ff  <= 16'h0000;
      dq_s3_ff  <= 16'h0000;
    end
    else
    begin
      rdy_s1_ff <= fl_done_flag_n;
      rdy_s2_ff <= rdy_s1_ff;
      rdy_s3_ff <= rdy_s2_ff;
      dq_s1_ff  <= fl_dq_i;
      dq_s2_ff  <= dq_s1_ff;
      dq_s3_ff  <= dq_s2_ff;
      if (rdy_s2_ff == rdy_s3_ff)
        rdy_ff <= rdy_s3_ff;
    end
  end

  // ************************************************************
  // Avalon-MM slave
  // ************************************************************
  // One wait cycle on every access keeps read data registered
  assign avs_waitrequest = (avs_read || avs_write) && !ack_ff;
  assign acc_wr          = avs_write && ack_ff;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      ack_ff <= 1'b0;
    else
      ack_ff <= (avs_read || avs_write) && !ack_ff;
  end

  // Read mux; unmapped words read zero
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      avs_readdata <= 32'h0000_0000;
    else
    begin
      unique case (avs_address)
        `PFH_REG_CTRL:   avs_readdata <= 32'h0000_0000;
        `PFH_REG_ADDR:   avs_readdata <= {11'h000, addr_ff};
        `PFH_REG_WDATA:  avs_readdata <= {16'h0000, wdata_ff};
        `PFH_REG_RDATA:  avs_readdata <= {16'h0000, rdata_ff};
        `PFH_REG_STATUS: avs_readdata <= {25'h000_0000, !fl_byte_n,
                                          fl_hv_en, estog_ff, tog_ff,
                                          rdy_ff, err_ff,
                                          state_ff != PFH_IDLE};
        `PFH_REG_TIM0:   avs_readdata <= {8'h00, tim0_ff};
        `PFH_REG_TIM1:   avs_readdata <= {8'h00, tim1_ff};
        default:         avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ************************************************************
  // Command launch
  // ************************************************************
  assign cmd = pfh_cmd_t'(avs_writedata[3:0]);
  assign go  = acc_wr && (avs_address == `PFH_REG_CTRL)
               && (cmd != PFH_CMD_NOP);
  // Writes while the flash works are refused unless forced,
  // the force bit leaves room for suspend and reset commands
  assign go_bad = go && ((state_ff != PFH_IDLE)
                  || ((cmd == PFH_CMD_WRITE) && !rdy_ff
                      && !avs_writedata[`PFH_CTRL_FORCE]));
  assign go_ok  = go && !go_bad;

  // Timing fields, all software programmable
  assign t_wp  = tim0_ff[15:12];
  assign t_wph = tim0_ff[19:16];
  assign t_acc = tim0_ff[23:20];

  // ************************************************************
  // Configuration and sticky status
  // ************************************************************
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      addr_ff  <= 21'h00_0000;
      wdata_ff <= 16'h0000;
      tim0_ff  <= {4'(`PFH_C_ACC), 4'(`PFH_C_WPH), 4'(`PFH_C_WP),
                   12'(`PFH_C_RP)};
      tim1_ff  <= {12'(`PFH_C_RSP), 12'(`PFH_C_READY_REC)};
    end
    else if (acc_wr)
    begin
      if (avs_address == `PFH_REG_ADDR)
        addr_ff <= avs_writedata[20:0];
      if (avs_address == `PFH_REG_WDATA)
        wdata_ff <= avs_writedata[15:0];
      if (avs_address == `PFH_REG_TIM0)
        tim0_ff <= avs_writedata[23:0];
      if (avs_address == `PFH_REG_TIM1)
        tim1_ff <= avs_writedata[23:0];
    end
  end

  // Write one to clear; a fresh event in the same cycle wins
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      err_ff   <= 1'b0;
      tog_ff   <= 1'b0;
      estog_ff <= 1'b0;
    end
    else
    begin
      if (go_bad)
        err_ff <= 1'b1;
      else if (acc_wr && (avs_address == `PFH_REG_STATUS)
               && avs_writedata[`PFH_ST_ERR])
        err_ff <= 1'b0;
      if (diff_vld_ff && diff_tog_ff)
        tog_ff <= 1'b1;
      else if (acc_wr && (avs_address == `PFH_REG_STATUS)
               && avs_writedata[`PFH_ST_TOG])
        tog_ff <= 1'b0;
      if (diff_vld_ff && diff_es_ff)
        estog_ff <= 1'b1;
      else if (acc_wr && (avs_address == `PFH_REG_STATUS)
               && avs_writedata[`PFH_ST_ESTOG])
        estog_ff <= 1'b0;
    end
  end

  // ************************************************************
  // Pin sequencer
  // ************************************************************
  // Every phase lasts its loaded count plus two cycles, so the
  // pins always err on the long side of each least time
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state_ff    <= PFH_IDLE;
      load_ff     <= 1'b0;
      value_ff    <= 12'h000;
      fl_addr     <= 21'h00_0000;
      fl_dq_o     <= 16'h0000;
      fl_dq_oe    <= 1'b0;
      fl_ce_n     <= 1'b1;
      fl_oe_n     <= 1'b1;
      fl_we_n     <= 1'b1;
      fl_byte_n   <= 1'b1;
      fl_reset_n  <= 1'b1;
      fl_hv_en    <= 1'b0;
      rdata_ff    <= 16'h0000;
      poll_ff     <= 1'b0;
      second_ff   <= 1'b0;
      busy_at_ff  <= 1'b0;
      stby_ff     <= 1'b0;
      diff_tog_ff <= 1'b0;
      diff_es_ff  <= 1'b0;
      diff_vld_ff <= 1'b0;
    end
    else
    begin
      load_ff     <= 1'b0;
      diff_vld_ff <= 1'b0;
      unique case (state_ff)
        PFH_IDLE:
        begin
          // A command launches at once: no delay after ready
          if (go_ok)
          begin
            load_ff <= 1'b1;
            unique case (cmd)
              PFH_CMD_READ, PFH_CMD_POLL:
              begin
                poll_ff   <= (cmd == PFH_CMD_POLL);
                second_ff <= 1'b0;
                fl_addr   <= addr_ff;
                fl_ce_n   <= 1'b0;
                fl_oe_n   <= 1'b0;
                value_ff  <= 12'(t_acc) + 12'(`PFH_C_SYNC);
                state_ff  <= PFH_RD;
              end
              PFH_CMD_WRITE, PFH_CMD_PROT, PFH_CMD_UNPROT:
              begin
                fl_addr <= addr_ff;
                if (cmd != PFH_CMD_WRITE)
                begin
                  fl_addr[`PFH_ADDR_B1] <= 1'b1;
                  fl_addr[`PFH_ADDR_B0] <= 1'b0;
                  fl_addr[`PFH_ADDR_B6] <=
                    (cmd == PFH_CMD_UNPROT);
                end
                // Output gate already high, so no read recovery
                fl_dq_o  <= wdata_ff;
                fl_dq_oe <= 1'b1;
                fl_ce_n  <= 1'b0;
                fl_we_n  <= 1'b0;
                value_ff <= 12'(t_wp);
                state_ff <= PFH_WR_LO;
              end
              PFH_CMD_RESET:
              begin
                // Remember whether an algorithm was under way
                busy_at_ff <= !rdy_ff;
                stby_ff    <= avs_writedata[`PFH_CTRL_STBY];
                fl_reset_n <= 1'b0;
                if (avs_writedata[`PFH_CTRL_STBY])
                  value_ff <= 12'(`PFH_C_RPD);
                else
                  value_ff <= tim0_ff[11:0];
                state_ff   <= PFH_RST_LO;
              end
              PFH_CMD_WAIT:
              begin
                value_ff <= 12'(`PFH_C_BUSY);
                state_ff <= PFH_BUSY_WAIT;
              end
              PFH_CMD_HV_ON:
              begin
                fl_hv_en <= 1'b1;
                value_ff <= tim1_ff[23:12];
                state_ff <= PFH_HV_WAIT;
              end
              PFH_CMD_HV_OFF:
              begin
                fl_hv_en <= 1'b0;
                value_ff <= 12'(`PFH_C_VIDR);
                state_ff <= PFH_HV_WAIT;
              end
              PFH_CMD_WIDTH:
              begin
                // Changed only while chip select is high
                fl_byte_n <= !avs_writedata[`PFH_CTRL_BYTE];
                if (avs_writedata[`PFH_CTRL_BYTE])
                  value_ff <= 12'(`PFH_C_FLQZ);
                else
                  value_ff <= 12'(`PFH_C_FHQV);
                state_ff <= PFH_BYTE_WAIT;
              end
              default:
                load_ff <= 1'b0;
            endcase
          end
        end
        PFH_RD:
        begin
          // Data settled long before, so stages agree here
          if (tif.expired)
          begin
            rdata_ff <= dq_s3_ff;
            if (poll_ff && second_ff)
            begin
              diff_tog_ff <= rdata_ff[`PFH_DQ_TOG]
                             ^ dq_s3_ff[`PFH_DQ_TOG];
              diff_es_ff  <= rdata_ff[`PFH_DQ_ESTOG]
                             ^ dq_s3_ff[`PFH_DQ_ESTOG];
              diff_vld_ff <= 1'b1;
            end
            // Both strobes rise between status reads
            fl_ce_n  <= 1'b1;
            fl_oe_n  <= 1'b1;
            load_ff  <= 1'b1;
            value_ff <= 12'(`PFH_C_GAP);
            state_ff <= PFH_GAP;
          end
        end
        PFH_GAP:
        begin
          if (tif.expired)
          begin
            if (poll_ff && !second_ff)
            begin
              second_ff <= 1'b1;
              fl_ce_n   <= 1'b0;
              fl_oe_n   <= 1'b0;
              load_ff   <= 1'b1;
              value_ff  <= 12'(t_acc) + 12'(`PFH_C_SYNC);
              state_ff  <= PFH_RD;
            end
            else
              state_ff <= PFH_IDLE;
          end
        end
        PFH_WR_LO:
        begin
          if (tif.expired)
          begin
            fl_we_n <= 1'b1;
            load_ff <= 1'b1;
            // Stretch the high phase so the cycle meets its minimum
            if ((5'(t_wp) + 5'(t_wph)) < 5'(`PFH_C_WC))
              value_ff <= 12'(`PFH_C_WC) - 12'(t_wp);
            else
              value_ff <= 12'(t_wph);
            state_ff <= PFH_WR_HI;
          end
        end
        PFH_WR_HI:
        begin
          if (tif.expired)
          begin
            fl_ce_n  <= 1'b1;
            fl_dq_oe <= 1'b0;
            state_ff <= PFH_IDLE;
          end
        end
        PFH_RST_LO:
        begin
          if (tif.expired)
          begin
            fl_reset_n <= 1'b1;
            load_ff    <= 1'b1;
            // An aborted algorithm needs the long recovery
            if (busy_at_ff && !stby_ff)
              value_ff <= tim1_ff[11:0];
            else
              value_ff <= 12'(`PFH_C_RH);
            state_ff <= PFH_RST_HI;
          end
        end
        PFH_RST_HI:
        begin
          if (tif.expired)
            state_ff <= PFH_IDLE;
        end
        PFH_BUSY_WAIT:
        begin
          // Flash ready flag is not trusted before this point
          if (tif.expired)
            state_ff <= PFH_RDY_WAIT;
        end
        PFH_RDY_WAIT:
        begin
          // Program or erase may run for seconds; no timeout here
          if (rdy_ff)
            state_ff <= PFH_IDLE;
        end
        PFH_HV_WAIT, PFH_BYTE_WAIT:
        begin
          if (tif.expired)
            state_ff <= PFH_IDLE;
        end
        default:
          state_ff <= PFH_IDLE;
      endcase
    end
  end

  assign fsm_state = state_ff;

endmodule // pfh_host

// *** tb/pfh_host_assertions.sv ***
module pfh_host_assertions (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Flash pins
  input wire logic fl_ce_n,
  input wire logic fl_oe_n,
  input wire logic fl_we_n,
  input wire logic fl_byte_n,
  input wire logic fl_reset_n,
  input wire logic fl_hv_en,
  input wire logic fl_dq_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic [11:0] rlo_ff;
  logic [11:0] hv_ff;
  // Dwell counters saturate, so a long hold never wraps to a false fail
  always_ff @(posedge ref_clk)
  begin
    rlo_ff <= (sys_rst | fl_reset_n) ? 12'h000 : rlo_ff + {11'h0, ~&rlo_ff};
    hv_ff  <= (sys_rst | ~fl_hv_en) ? 12'h000 : hv_ff + {11'h0, ~&hv_ff};
  end
  sequence s_we_lo; !fl_we_n ##1 !fl_we_n; endsequence
  sequence s_we_hi; fl_we_n ##1 fl_we_n; endsequence
  AST_WE_LOW: assert property ($fell(fl_we_n) |-> s_we_lo)
    else $error("write strobe low too short");
  AST_WE_HIGH: assert property ($rose(fl_we_n) |-> s_we_hi)
    else $error("write strobe high too short");
  AST_WR_CYCLE: assert property ($fell(fl_we_n) |-> !fl_ce_n [*3])
    else $error("write cycle too short");
  AST_WR_DATA: assert property (!fl_we_n |-> fl_dq_oe && !fl_ce_n)
    else $error("write strobe without data or select");
  AST_RST_PULSE: assert property ($rose(fl_reset_n) |-> rlo_ff >= 12'd20)
    else $error("flash reset pulse too short");
  AST_READ_REC: assert property ($rose(fl_reset_n) |-> fl_oe_n [*3])
    else $error("read too soon after flash reset");
  AST_HV_SETUP: assert property (fl_hv_en && !fl_we_n |-> hv_ff >= 12'd160)
    else $error("write too soon after high voltage");
  AST_OE_GAP: assert property ($rose(fl_oe_n) |-> fl_oe_n [*3])
    else $error("output gate not toggled between reads");
  AST_BYTE_CE: assert property ($changed(fl_byte_n) |-> fl_ce_n && $past(fl_ce_n))
    else $error("width select changed while selected");
endmodule // pfh_host_assertions
bind pfh_host pfh_host_assertions u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n),
  .fl_byte_n(fl_byte_n), .fl_reset_n(fl_reset_n), .fl_hv_en(fl_hv_en),
  .fl_dq_oe(fl_dq_oe));

// *** tb/pfh_flash_model.sv ***
module pfh_flash_model (
  // Clock for busy timing
  input wire logic ref_clk,
  // Host side pins
  input wire logic [20:0] fl_addr,
  input wire logic [15:0] fl_dq_o,
  input wire logic        fl_ce_n,
  input wire logic        fl_oe_n,
  input wire logic        fl_we_n,
  input wire logic        fl_byte_n,
  input wire logic        fl_reset_n,
  output logic     [15:0] fl_dq_i,
  output logic            fl_done_flag_n,
  // Last write seen, for the bench
  output logic     [20:0] wa,
  output logic     [15:0] wd
);
  timeunit 1ns;
  timeprecision 100ps;
  int          busy;
  logic [15:0] mem;
  logic [1:0]  tg;
  logic [15:0] pat;
  initial
  begin
    busy = 0; tg = 2'b00; mem = 16'hFFFF; pat = 16'h0000; wa = '0; wd = '0;
  end
  // Strobe rise latches data and starts programming at once
  always @(posedge fl_we_n)
    if (!fl_ce_n && fl_reset_n)
    begin
      wa = fl_addr; wd = fl_dq_o; mem = fl_dq_o;
      busy = fl_byte_n ? 280 : 200;
    end
  // Reset aborts the algorithm; released lines show a moving pattern
  always @(posedge ref_clk)
  begin
    pat <= pat + 16'h1357;
    if (!fl_reset_n) busy = 0;
    else if (busy != 0) busy = busy - 1;
  end
  // Each status read while busy flips DQ6, and DQ2 only when address bits 20:15 are zero
  always @(negedge fl_oe_n)
    if (busy != 0) tg = tg ^ {fl_addr[20:15] == 6'h00, 1'b1};
  assign fl_done_flag_n = (busy == 0);
  assign fl_dq_i = (fl_ce_n | fl_oe_n) ? pat
    : (busy != 0) ? {9'h000, tg[0], 3'h0, tg[1], 2'h0}
    : fl_byte_n ? mem : {pat[15:8], mem[7:0]};
endmodule // pfh_flash_model

// *** tb/testbench.sv ***
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import pfh_pkg::*;
  logic ref_clk, sys_rst, avs_read, avs_write, avs_waitrequest;
  logic [2:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [20:0] fl_addr, wa;
  logic [15:0] fl_dq_i, fl_dq_o, wd;
  logic fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n, fl_byte_n, fl_reset_n;
  logic fl_hv_en, fl_done_flag_n;
  pfh_state_t fsm_state;
  int errors, comparisons;
  int rlo, n0;
  // Counts cycles with the flash reset pin low
  always @(posedge ref_clk) if (!fl_reset_n) rlo <= rlo + 1;
  pfh_host dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .fl_addr(fl_addr), .fl_dq_i(fl_dq_i), .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe),
    .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n),
    .fl_byte_n(fl_byte_n), .fl_reset_n(fl_reset_n), .fl_hv_en(fl_hv_en),
    .fl_done_flag_n(fl_done_flag_n), .fsm_state(fsm_state));
  pfh_flash_model u_flash (.ref_clk(ref_clk), .fl_addr(fl_addr),
    .fl_dq_o(fl_dq_o), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n),
    .fl_byte_n(fl_byte_n), .fl_reset_n(fl_reset_n), .fl_dq_i(fl_dq_i),
    .fl_done_flag_n(fl_done_flag_n), .wa(wa), .wd(wd));
  task automatic print_verdict;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Avalon access: held until the rising edge that samples waitrequest low
  task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
    int n;
    avs_address <= a; avs_write <= w; avs_read <= !w; avs_writedata <= d;
    n = 0;
    do begin @(posedge ref_clk); n++; end
    while (avs_waitrequest !== 1'b0 && n < 100);
    if (avs_waitrequest !== 1'b0) begin errors++; print_verdict; end
    q = avs_readdata;
    avs_read <= 1'b0; avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask
  // Issue a command and poll until the controller is idle again
  task automatic cmd(input logic [31:0] c);
    int n;
    bus(1'b1, 3'h0, c);
    n = 0;
    do begin bus(1'b0, 3'h4, 32'h0); n++; end
    while (q[0] !== 1'b0 && n < 2000);
    if (n >= 2000) begin errors++; print_verdict; end
  endtask
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial
  begin
    sys_rst = 1'b1; avs_read = 1'b0; avs_write = 1'b0; avs_address = 3'h0;
    avs_writedata = 32'h0; errors = 0; comparisons = 0; rlo = 0; n0 = 0;
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    bus(1'b0, 3'h5, 32'h0); chk("tim0", q, 32'h0032_2014);
    bus(1'b0, 3'h6, 32'h0); chk("tim1", q, 32'h000A_030C);
    bus(1'b0, 3'h7, 32'h0); chk("unmapped", q, 32'h0);
    bus(1'b1, 3'h1, 32'h0000_1234); bus(1'b1, 3'h2, 32'h0000_BEEF);
    cmd(32'h2); chk("waddr", {11'h0, wa}, 32'h1234);
    chk("wdata", {16'h0, wd}, 32'hBEEF);
    cmd(32'h2); bus(1'b0, 3'h4, 32'h0); chk("refused", q[2:1], 2'b01);
    cmd(32'h5); bus(1'b0, 3'h4, 32'h0); chk("tog", q[4:3], 2'b11);
    bus(1'b1, 3'h4, 32'h1A); cmd(32'h4); cmd(32'h1);
    bus(1'b0, 3'h4, 32'h0); chk("status", q[6:0], 7'h04);
    bus(1'b0, 3'h3, 32'h0); chk("rdata", q, 32'hBEEF);
    // Sector outside the suspended range: only the general bit moves
    bus(1'b1, 3'h1, 32'h0018_0000); cmd(32'h2); cmd(32'h5);
    bus(1'b0, 3'h4, 32'h0); chk("estog", q[4:3], 2'b01);
    bus(1'b1, 3'h4, 32'h1A); n0 = rlo; cmd(32'h3); cmd(32'h4);
    chk("rst_lo", rlo - n0, 32'd22);
    bus(1'b0, 3'h4, 32'h0); chk("abort", q[2:0], 3'h4);
    cmd(32'h6); bus(1'b0, 3'h4, 32'h0); chk("hv", q[5], 1'b1);
    cmd(32'h8); chk("prot", {wa[6], wa[1], wa[0]}, 3'b010);
    cmd(32'h4); cmd(32'h9);
    chk("unprot", {wa[6], wa[1], wa[0]}, 3'b110);
    cmd(32'h4); cmd(32'h7); cmd(32'h1A); bus(1'b0, 3'h4, 32'h0);
    chk("byte", {q[6], fl_byte_n}, 2'b10);
    cmd(32'h4A); chk("word", fl_byte_n, 1'b1);
    n0 = rlo; cmd(32'h23); chk("standby", rlo - n0, 32'd802);
    chk("fsm", fsm_state, PFH_IDLE);
    print_verdict;
  end
endmodule // testbench
